/* File: hw/nvmac_consts.vh */
// Constants for the nonvolatile memory access controller
`ifndef NVMAC_CONSTS_VH
`define NVMAC_CONSTS_VH
`define NVMAC_A_DATA_LO   9'h10c
`define NVMAC_A_ADDR_LO   9'h10d
`define NVMAC_A_DATA_HI   9'h10e
`define NVMAC_A_ADDR_HI   9'h10f
`define NVMAC_A_CTRL      9'h18c
`define NVMAC_A_UNLOCK    9'h18d
`define NVMAC_KEY1        8'h55
`define NVMAC_KEY2        8'haa
`define NVMAC_B_SPACE     7
`define NVMAC_B_ABORT     3
`define NVMAC_B_ALLOW     2
`define NVMAC_B_WR        1
`define NVMAC_B_RD        0
`define NVMAC_DH_MASK     8'h3f
`define NVMAC_AH_MASK     8'h0f
`define NVMAC_CLK_MHZ     200
`define NVMAC_PWRT_MS     64
`define NVMAC_WRITE_US    5
`define NVMAC_EE_DEPTH    256
`define NVMAC_PM_DEPTH    4096
`define NVMAC_PM_BLANK    14'h3fff
`endif

/* File: hw/nvmac_timer.v */
// Down counter that times one long interval after a start pulse
`timescale 1ns/1ps
module nvmac_timer #(
  parameter [31:0] CYCLES = 32'd10
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        start,
  output reg         busy,
  output reg         done
);
  reg [31:0] count_q;

  // ==========================================================
  // Count down and pulse done at the end
  always @(posedge clock)
  begin
    if (rst)
    begin
      count_q <= 32'h0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        count_q <= CYCLES;
        busy    <= 1'b1;
      end
      else if (busy)
      begin
        if (count_q <= 32'h1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count_q <= count_q - 32'h1;
      end
    end
  end
endmodule

/* File: hw/nvmac_top.v */
// Data EEPROM and program flash indirect access controller
`timescale 1ns/1ps
`include "nvmac_consts.vh"
module nvmac_top #(
  parameter [31:0] PWRT_CYCLES  = `NVMAC_PWRT_MS * 1000 * `NVMAC_CLK_MHZ,
  parameter [31:0] WRITE_CYCLES = `NVMAC_WRITE_US * `NVMAC_CLK_MHZ
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        por,
  input  wire        abort_reset,
  input  wire [8:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  input  wire        write_done_clr,
  output reg         write_done_flag,
  output reg         instr_suppress,
  input  wire        code_protect,
  input  wire        prog_req,
  input  wire [11:0] prog_addr,
  output reg  [13:0] prog_rdata,
  output reg         prog_denied
);
  // ==========================================================
  // Storage arrays
  reg [7:0]  ee_mem [0:`NVMAC_EE_DEPTH-1];
  reg [13:0] pm_mem [0:`NVMAC_PM_DEPTH-1];

  // Registers
  reg [7:0] mem_data_low_q;
  reg [7:0] mem_addr_low_q;
  reg [5:0] mem_data_high_q;
  reg [3:0] mem_addr_high_q;
  reg       space_select_q;
  reg       write_abort_q;
  reg       write_allow_q;
  reg       wr_q;
  reg       rd_q;
  reg [2:0] pm_stage_q;
  reg [2:0] unlock_q;
  reg       pwrt_busy_q;
  reg [31:0] pwrt_cnt_q;
  reg       por_s1_q;
  reg       por_s2_q;
  reg       abr_s1_q;
  reg       abr_s2_q;
  reg       cp_s1_q;
  reg       cp_s2_q;
  reg       pr_s1_q;
  reg       pr_s2_q;
  reg [11:0] pa_s1_q;
  reg [11:0] pa_s2_q;
  integer    pm_i;

  // Unlock sequence states, one-hot
  localparam [2:0] UNL_IDLE = 3'b001;
  localparam [2:0] UNL_KEY1 = 3'b010;
  localparam [2:0] UNL_OPEN = 3'b100;

  // Program read states, one-hot
  localparam [2:0] PMR_IDLE  = 3'b001;
  localparam [2:0] PMR_WAIT  = 3'b010;
  localparam [2:0] PMR_FETCH = 3'b100;

  // Synchronised inputs
  wire      por_sync   = por_s2_q;
  wire      abort_sync = abr_s2_q;
  wire      cp_sync    = cp_s2_q;
  wire      preq_sync  = pr_s2_q;

  wire      tmr_busy;
  wire      tmr_done;
  wire      wr_start;
  wire [11:0] pm_addr;

  // ==========================================================
  // Register address decode
  function hit;
    input [8:0] a;
    input [8:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire wr_ctrl   = reg_wr && hit(reg_addr, `NVMAC_A_CTRL);
  wire wr_unlock = reg_wr && hit(reg_addr, `NVMAC_A_UNLOCK);
  wire set_wr    = wr_ctrl && reg_wdata[`NVMAC_B_WR];
  wire set_rd    = wr_ctrl && reg_wdata[`NVMAC_B_RD];
  wire new_space = wr_ctrl ? reg_wdata[`NVMAC_B_SPACE] : space_select_q;
  wire new_allow = wr_ctrl ? reg_wdata[`NVMAC_B_ALLOW] : write_allow_q;

  // Write starts only unlocked, allowed, data space, idle, after timer
  assign wr_start = set_wr && !wr_q && !new_space
                    && write_allow_q && new_allow
                    && unlock_q == UNL_OPEN
                    && !pwrt_busy_q;
  assign pm_addr  = {mem_addr_high_q, mem_addr_low_q};

  // ==========================================================
  // Write cycle timer
  nvmac_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clock (clock),
    .rst   (rst | abort_sync),
    .start (wr_start),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // ==========================================================
  // Program array starts erased, programmed outside this block
  initial
  begin
    for (pm_i = 0; pm_i < `NVMAC_PM_DEPTH; pm_i = pm_i + 1)
      pm_mem[pm_i] = `NVMAC_PM_BLANK;
  end

  // ==========================================================
  // Input synchronisers
  always @(posedge clock)
  begin
    por_s1_q <= por;
    por_s2_q <= por_s1_q;
    abr_s1_q <= abort_reset;
    abr_s2_q <= abr_s1_q;
    cp_s1_q  <= code_protect;
    cp_s2_q  <= cp_s1_q;
    pr_s1_q  <= prog_req;
    pr_s2_q  <= pr_s1_q;
    pa_s1_q  <= prog_addr;
    pa_s2_q  <= pa_s1_q;
  end

  // ==========================================================
  // Power-up timer blocks writes
  always @(posedge clock)
  begin
    if (rst || por_sync)
    begin
      pwrt_busy_q <= 1'b1;
      pwrt_cnt_q  <= 32'h0;
    end
    else if (pwrt_busy_q)
    begin
      pwrt_cnt_q <= pwrt_cnt_q + 32'h1;
      if (pwrt_cnt_q >= PWRT_CYCLES - 32'h1)
        pwrt_busy_q <= 1'b0;
    end
  end

  // ==========================================================
  // Unlock sequence tracker, no storage readable
  always @(posedge clock)
  begin
    if (rst || abort_sync)
      unlock_q <= UNL_IDLE;
    else if (wr_unlock)
    begin
      if (reg_wdata == `NVMAC_KEY1)
        unlock_q <= UNL_KEY1;
      else
      begin
        case (unlock_q)
          UNL_KEY1:
            if (reg_wdata == `NVMAC_KEY2)
              unlock_q <= UNL_OPEN;
            else
              unlock_q <= UNL_IDLE;
          default:
            unlock_q <= UNL_IDLE;
        endcase
      end
    end
    else if (reg_wr)
      unlock_q <= UNL_IDLE;
  end

  // ==========================================================
  // Control register bits
  always @(posedge clock)
  begin
    if (rst)
    begin
      space_select_q <= 1'b0;
      write_allow_q  <= 1'b0;
      wr_q           <= 1'b0;
      rd_q           <= 1'b0;
    end
    else
    begin
      if (abort_sync)
      begin
        wr_q           <= 1'b0;
        space_select_q <= 1'b0;
        write_allow_q  <= 1'b0;
      end
      else
      begin
        if (wr_ctrl)
        begin
          space_select_q <= reg_wdata[`NVMAC_B_SPACE];
          write_allow_q  <= reg_wdata[`NVMAC_B_ALLOW];
        end
        // Hardware clears, software only sets
        if (wr_start)
          wr_q <= 1'b1;
        else if (tmr_done)
          wr_q <= 1'b0;
      end
      // Read request self clears next cycle
      rd_q <= set_rd && !wr_q && !tmr_busy;
    end
  end

  // ==========================================================
  // Abort flag: set by reset cutting a write, kept over rst
  always @(posedge clock)
  begin
    if (por_sync)
      write_abort_q <= 1'b0;
    else if ((abort_sync || rst) && tmr_busy)
      write_abort_q <= 1'b1;
    else if (tmr_done)
      write_abort_q <= 1'b0;
    else if (wr_ctrl)
      write_abort_q <= reg_wdata[`NVMAC_B_ABORT];
  end

  // ==========================================================
  // Data and address registers, not cleared by rst
  always @(posedge clock)
  begin
    if (por_sync)
    begin
      mem_data_low_q  <= 8'h00;
      mem_addr_low_q  <= 8'h00;
      mem_data_high_q <= 6'h00;
      mem_addr_high_q <= 4'h0;
    end
    else if (rd_q && !space_select_q)
      mem_data_low_q <= ee_mem[mem_addr_low_q];
    else if (pm_stage_q == PMR_FETCH)
    begin
      mem_data_low_q  <= pm_mem[pm_addr][7:0];
      mem_data_high_q <= pm_mem[pm_addr][13:8];
    end
    else if (reg_wr && !tmr_busy)
    begin
      case (reg_addr)
        `NVMAC_A_DATA_LO: mem_data_low_q  <= reg_wdata;
        `NVMAC_A_ADDR_LO: mem_addr_low_q  <= reg_wdata;
        `NVMAC_A_DATA_HI: mem_data_high_q <= reg_wdata[5:0];
        `NVMAC_A_ADDR_HI: mem_addr_high_q <= reg_wdata[3:0];
        default:          mem_data_low_q  <= mem_data_low_q;
      endcase
    end
  end

  // ==========================================================
  // Program read pipeline: second cycle does the access
  always @(posedge clock)
  begin
    if (rst)
    begin
      pm_stage_q     <= PMR_IDLE;
      instr_suppress <= 1'b0;
    end
    else
    begin
      if (rd_q && space_select_q)
        pm_stage_q <= PMR_WAIT;
      else
      begin
        case (pm_stage_q)
          PMR_WAIT: pm_stage_q <= PMR_FETCH;
          default:  pm_stage_q <= PMR_IDLE;
        endcase
      end
      instr_suppress <= (pm_stage_q == PMR_WAIT);
    end
  end

  // ==========================================================
  // EEPROM array write: erase then program in one step
  always @(posedge clock)
  begin
    if (tmr_done && !abort_sync)
      ee_mem[mem_addr_low_q] <= mem_data_low_q;
  end

  // ==========================================================
  // Write done flag, set wins over clear
  always @(posedge clock)
  begin
    if (rst)
      write_done_flag <= 1'b0;
    else if (tmr_done && !abort_sync)
      write_done_flag <= 1'b1;
    else if (write_done_clr)
      write_done_flag <= 1'b0;
  end

  // ==========================================================
  // External programmer port, blocked under code protect
  always @(posedge clock)
  begin
    if (rst)
    begin
      prog_rdata  <= 14'h0000;
      prog_denied <= 1'b0;
    end
    else if (preq_sync)
    begin
      prog_denied <= cp_sync;
      prog_rdata  <= cp_sync ? 14'h0000 : pm_mem[pa_s2_q];
    end
  end

  // ==========================================================
  // Register read mux, unimplemented bits zero
  always @(posedge clock)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `NVMAC_A_DATA_LO: reg_rdata <= mem_data_low_q;
        `NVMAC_A_ADDR_LO: reg_rdata <= mem_addr_low_q;
        `NVMAC_A_DATA_HI: reg_rdata <= {2'b00, mem_data_high_q};
        `NVMAC_A_ADDR_HI: reg_rdata <= {4'h0, mem_addr_high_q};
        `NVMAC_A_CTRL:    reg_rdata <= {space_select_q, 3'b000,
                                        write_abort_q, write_allow_q,
                                        wr_q, rd_q};
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

/* File: tb/nvmac_props.sv */
// Port-level property checker for the memory access controller
`timescale 1ns/1ps
`include "nvmac_consts.vh"
module nvmac_props (
  input wire        clock,
  input wire        rst,
  input wire [8:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        write_done_clr,
  input wire        write_done_flag,
  input wire        instr_suppress,
  input wire [13:0] prog_rdata,
  input wire        prog_denied
);
  // Decoded read and write strobes
  wire rd_unl = reg_rd && reg_addr == `NVMAC_A_UNLOCK;
  wire rd_ah  = reg_rd && reg_addr == `NVMAC_A_ADDR_HI;
  wire rd_dh  = reg_rd && reg_addr == `NVMAC_A_DATA_HI;
  wire rd_ctl = reg_rd && reg_addr == `NVMAC_A_CTRL;
  wire wr_prd = reg_wr && reg_addr == `NVMAC_A_CTRL && reg_wdata[7] &&
                reg_wdata[0];

  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  // ====================
  // Register readback
  unlock_zero_a:
    assert property (rd_unl |=> reg_rdata == 8'h00)
    else $error("unlock port read not zero");
  addrhi_bits_a:
    assert property (rd_ah |=> reg_rdata[7:4] == 4'h0)
    else $error("address high spare bits set");
  datahi_bits_a:
    assert property (rd_dh |=> reg_rdata[7:6] == 2'h0)
    else $error("data high spare bits set");
  ctrl_bits_a:
    assert property (rd_ctl |=> reg_rdata[6:4] == 3'h0)
    else $error("control spare bits set");
  prog_nowr_a:
    assert property (rd_ctl |=> !(reg_rdata[7] && reg_rdata[1]))
    else $error("write bit set in program space");

  // ====================
  // Flags and programmer side
  done_hold_a:
    assert property (write_done_flag && !write_done_clr |=> write_done_flag)
    else $error("write done flag lost without clear");
  denied_zero_a:
    assert property (prog_denied |-> prog_rdata == 14'h0000)
    else $error("denied programmer read returned data");
  supp_pulse_a:
    assert property (instr_suppress |=> !instr_suppress)
    else $error("suppress longer than one cycle");
  supp_cause_a:
    assert property ($rose(instr_suppress) |-> $past(wr_prd, 3))
    else $error("suppress not three cycles after program read");
  cover property (instr_suppress);
  cover property ($rose(write_done_flag));
  cover property (prog_denied);
endmodule

bind nvmac_top nvmac_props u_props (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .write_done_clr(write_done_clr), .write_done_flag(write_done_flag),
  .instr_suppress(instr_suppress), .prog_rdata(prog_rdata),
  .prog_denied(prog_denied)
);

/* File: tb/nvmac_top_tb_top.sv */
// Self-checking bench for the memory access controller
`timescale 1ns/1ps
`include "nvmac_consts.vh"
module nvmac_top_tb_top;
  localparam [31:0] WCYC = 32'd20;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         por = 1'b1;
  reg         abort_reset = 1'b0;
  reg  [8:0]  reg_addr = 9'h000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         write_done_clr = 1'b0;
  reg         code_protect = 1'b0;
  reg         prog_req = 1'b0;
  reg  [11:0] prog_addr = 12'h000;
  wire [7:0]  reg_rdata;
  wire        write_done_flag;
  wire        instr_suppress;
  wire [13:0] prog_rdata;
  wire        prog_denied;
  integer     bad_count = 0;
  integer     n_checks = 0;
  reg  [7:0]  v;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  nvmac_top #(.PWRT_CYCLES(32'd50), .WRITE_CYCLES(WCYC)) u_dut (
    .clock(clock), .rst(rst), .por(por), .abort_reset(abort_reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .write_done_clr(write_done_clr), .write_done_flag(write_done_flag),
    .instr_suppress(instr_suppress), .code_protect(code_protect),
    .prog_req(prog_req), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .prog_denied(prog_denied)
  );

  // ====================
  // Bus and compare tasks
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wreg(input [8:0] a, input [7:0] d);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rchk(input [8:0] a, input [7:0] e);
    begin
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      chk(v, e);
    end
  endtask
  task arm(input [7:0] k1, input [7:0] k2, input [7:0] c);
    begin
      wreg(`NVMAC_A_UNLOCK, k1);
      wreg(`NVMAC_A_UNLOCK, k2);
      wreg(`NVMAC_A_CTRL, c);
    end
  endtask
  task ee_rd(input [7:0] a, input [7:0] e);
    begin
      wreg(`NVMAC_A_ADDR_LO, a);
      wreg(`NVMAC_A_CTRL, 8'h01);
      rchk(`NVMAC_A_DATA_LO, e);
    end
  endtask
  task start_wr(input [7:0] a, input [7:0] d, input [7:0] k1);
    begin
      wreg(`NVMAC_A_ADDR_LO, a);
      wreg(`NVMAC_A_DATA_LO, d);
      wreg(`NVMAC_A_CTRL, 8'h04);
      arm(k1, 8'haa, 8'h06);
    end
  endtask

  // ====================
  // Scenarios
  task t_write(input [7:0] a, input [7:0] d);
    integer i;
    begin
      start_wr(a, d, 8'h55);
      rchk(`NVMAC_A_CTRL, 8'h06);
      wreg(`NVMAC_A_CTRL, 8'h00);
      rchk(`NVMAC_A_CTRL, 8'h02);
      wreg(`NVMAC_A_DATA_LO, ~d);
      for (i = 0; i < 60 && write_done_flag !== 1'b1; i = i + 1)
        @(posedge clock);
      #1 chk(write_done_flag, 1'b1);
      rchk(`NVMAC_A_CTRL, 8'h00);
      rchk(`NVMAC_A_DATA_LO, d);
      wreg(`NVMAC_A_DATA_LO, ~d);
      rchk(`NVMAC_A_DATA_LO, ~d);
      ee_rd(a, d);
      @(posedge clock);
      write_done_clr <= 1'b1;
      @(posedge clock);
      write_done_clr <= 1'b0;
      #1 chk(write_done_flag, 1'b0);
    end
  endtask
  task t_refuse;
    begin
      wreg(`NVMAC_A_DATA_LO, 8'h99);
      wreg(`NVMAC_A_CTRL, 8'h00);
      arm(8'h55, 8'haa, 8'h02);
      rchk(`NVMAC_A_CTRL, 8'h00);
      start_wr(8'h00, 8'h99, 8'haa);
      rchk(`NVMAC_A_CTRL, 8'h04);
      wreg(`NVMAC_A_CTRL, 8'h84);
      arm(8'h55, 8'haa, 8'h86);
      rchk(`NVMAC_A_CTRL, 8'h84);
      repeat (WCYC + 5) @(posedge clock);
      #1 chk(write_done_flag, 1'b0);
      ee_rd(8'h00, 8'h3c);
    end
  endtask
  task t_prog;
    begin
      wreg(`NVMAC_A_ADDR_HI, 8'hff);
      rchk(`NVMAC_A_ADDR_HI, 8'h0f);
      wreg(`NVMAC_A_DATA_HI, 8'hc0);
      rchk(`NVMAC_A_DATA_HI, 8'h00);
      rchk(`NVMAC_A_UNLOCK, 8'h00);
      rchk(9'h100, 8'h00);
      wreg(`NVMAC_A_CTRL, 8'h81);
      repeat (2) @(posedge clock);
      #1 chk(instr_suppress, 1'b1);
      rchk(`NVMAC_A_ADDR_HI, 8'h0f);
      rchk(`NVMAC_A_DATA_HI, 8'h3f);
      rchk(`NVMAC_A_DATA_LO, 8'hff);
    end
  endtask
  task t_abort;
    begin
      start_wr(8'h77, 8'hc3, 8'h55);
      abort_reset <= 1'b1;
      repeat (3) @(posedge clock);
      abort_reset <= 1'b0;
      repeat (4) @(posedge clock);
      rchk(`NVMAC_A_CTRL, 8'h08);
      rchk(`NVMAC_A_ADDR_LO, 8'h77);
      rchk(`NVMAC_A_DATA_LO, 8'hc3);
      wreg(`NVMAC_A_CTRL, 8'h00);
    end
  endtask
  task t_protect;
    begin
      code_protect <= 1'b1;
      prog_req <= 1'b1;
      prog_addr <= 12'h123;
      repeat (6) @(posedge clock);
      #1 chk(prog_denied, 1'b1);
      chk(prog_rdata, 14'h0000);
      @(posedge clock);
      code_protect <= 1'b0;
      repeat (6) @(posedge clock);
      #1 chk(prog_denied, 1'b0);
      chk(prog_rdata, `NVMAC_PM_BLANK);
      prog_req <= 1'b0;
    end
  endtask
  task t_pwrt;
    begin
      start_wr(8'h10, 8'h5a, 8'h55);
      rchk(`NVMAC_A_CTRL, 8'h04);
      repeat (60) @(posedge clock);
    end
  endtask
  task summarize;
    begin
      if (bad_count == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Main sequence: reset, early write, then scenarios
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    por <= 1'b0;
    repeat (3) @(posedge clock);
    t_pwrt;
    t_write(8'hff, 8'ha5);
    t_write(8'h00, 8'h3c);
    ee_rd(8'hff, 8'ha5);
    t_refuse;
    t_prog;
    t_abort;
    t_protect;
    summarize;
  end

  // Watchdog against a hung handshake
  initial
  begin
    #20000;
    bad_count = bad_count + 1;
    summarize;
  end
endmodule
